// File: common/bridge_cfg_pkg.sv
package bridge_cfg_pkg;

    // ========================================================================
    // Configuration offsets (byte offsets in configuration space).
    // ========================================================================
    localparam logic [7:0] MEM_BASE_OFFSET = 8'h20;
    localparam logic [7:0] SEC_STATUS_OFFSET = 8'h1e;
    localparam logic [7:0] MEM_LIMIT_OFFSET = 8'h22;

    // ========================================================================
    // Status bit positions.
    // ========================================================================
    localparam int DET_PARITY_BIT = 15;
    localparam int RX_SYS_ERR_BIT = 14;
    localparam int RX_MASTER_ABORT_BIT = 13;
    localparam int RX_ABORT_BIT = 12;
    localparam int SENT_ABORT_BIT = 11;
    localparam int MASTER_PARITY_BIT = 8;

    // ========================================================================
    // Field layout of the memory base and limit registers.
    // ========================================================================
    localparam int WIN_FIELD_LSB = 4;
    localparam int WIN_FIELD_W = 12;
    localparam int ADDR_LOW_W = 20;
    localparam logic [15:0] MEM_BASE_RESET = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    // Status bits that software may clear by writing one.
    localparam logic [15:0] STATUS_W1C_MASK = 16'hf900;

    // Traffic class of a poisoned packet, as seen by the parity matrix.
    typedef enum logic [1:0]
    {
        TRAFFIC_OB_POSTED,
        TRAFFIC_OB_COMPL,
        TRAFFIC_IB_POSTED,
        TRAFFIC_IB_COMPL
    } traffic_type;

    // Event reported by the port logic in one cycle.
    typedef struct packed
    {
        logic rx_completer_abort;
        logic completed_with_abort;
        logic poison_seen;
        traffic_type poison_class;
        logic poisoned_write_sent;
    } port_event_type;

    // Configuration access request.
    typedef struct packed
    {
        logic rd;
        logic wr;
        logic [7:0] offset;
        logic [1:0] byte_en;
        logic [15:0] wdata;
    } cfg_req_type;

endpackage

// File: test/bridge_secondary_status_and_mem_base_tb_top.sv
`timescale 1ns/1ps
module bridge_secondary_status_and_mem_base_tb_top;
    import bridge_cfg_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    cfg_req_type cfg_req = '0;
    logic [15:0] cfg_rdata, mem_window_base_field;
    logic cfg_hit, mem_to_port, up_det, up_mas;
    port_event_type port_event;
    logic parity_response_enable = 1'b0;
    logic upstream_rx_target_abort = 1'b0;
    logic rx_system_error = 1'b0;
    logic rx_unsupported_compl = 1'b0;
    logic [15:0] mem_limit_value = 16'h0000;
    logic mem_req_valid = 1'b0;
    logic [31:0] mem_req_addr = 32'h00000000;
    logic upstream_parity_clear = 1'b0;
    traffic_type cls;
    int err_count = 0;
    int checks = 0;
    always #2.5 clock = ~clock;
    link_partner_model partner (.clock(clock), .port_event(port_event));
    bridge_secondary_status_and_mem_base dut (.clock(clock), .resetn(resetn),
        .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit),
        .port_event(port_event), .parity_response_enable(parity_response_enable),
        .upstream_rx_target_abort(upstream_rx_target_abort),
        .rx_system_error(rx_system_error), .rx_unsupported_compl(rx_unsupported_compl),
        .mem_limit_value(mem_limit_value), .mem_req_valid(mem_req_valid),
        .mem_req_addr(mem_req_addr), .mem_to_port(mem_to_port),
        .upstream_detected_parity_flag(up_det), .upstream_master_parity_flag(up_mas),
        .upstream_parity_clear(upstream_parity_clear),
        .mem_window_base_field(mem_window_base_field));
    task automatic final_report;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cfg_wr(input logic [7:0] off, input logic [15:0] d,
        input logic [1:0] be = 2'h3);
        @(negedge clock);
        cfg_req = '{1'b0, 1'b1, off, be, d};
        @(negedge clock);
        cfg_req = '0;
    endtask
    task automatic cfg_rd(input string name, input logic [7:0] off, input logic [15:0] exp);
        @(negedge clock);
        cfg_req = '{1'b1, 1'b0, off, 2'h0, 16'h0000};
        #1;
        check("cfg_hit", {15'h0000, cfg_hit},
            {15'h0000, off == SEC_STATUS_OFFSET || off == MEM_BASE_OFFSET});
        @(negedge clock);
        cfg_req = '0;
        check(name, cfg_rdata, exp);
    endtask
    task automatic probe(input logic [31:0] a, input logic exp);
        @(negedge clock);
        mem_req_valid = 1'b1;
        mem_req_addr = a;
        @(negedge clock);
        mem_req_valid = 1'b0;
        check("mem_to_port", {15'h0000, mem_to_port}, {15'h0000, exp});
    endtask
    initial
    begin
        repeat (5) @(negedge clock);
        resetn = 1'b1;
        cfg_rd("base reset", MEM_BASE_OFFSET, MEM_BASE_RESET);
        cfg_rd("status reset", SEC_STATUS_OFFSET, STATUS_RESET);
        cfg_wr(MEM_BASE_OFFSET, 16'hffff);
        cfg_rd("base rw", MEM_BASE_OFFSET, 16'hfff0);
        cfg_wr(MEM_BASE_OFFSET, 16'h0000, 2'h1);
        cfg_rd("base low lane", MEM_BASE_OFFSET, 16'hff00);
        cfg_wr(SEC_STATUS_OFFSET, 16'hffff);
        cfg_rd("status ro", SEC_STATUS_OFFSET, 16'h0000);
        cfg_rd("unmapped", 8'h40, 16'h0000);
        partner.send('{1'b1, 1'b0, 1'b0, TRAFFIC_OB_POSTED, 1'b0});
        cfg_wr(SEC_STATUS_OFFSET, 16'h0000);
        cfg_rd("rx abort", SEC_STATUS_OFFSET, 16'h1000);
        cfg_wr(SEC_STATUS_OFFSET, 16'h1000, 2'h1);
        cfg_rd("rx abort lane", SEC_STATUS_OFFSET, 16'h1000);
        cfg_wr(SEC_STATUS_OFFSET, 16'h1000);
        cfg_rd("rx abort clear", SEC_STATUS_OFFSET, 16'h0000);
        partner.send('{1'b0, 1'b1, 1'b0, TRAFFIC_OB_POSTED, 1'b0});
        cfg_rd("sent abort gated", SEC_STATUS_OFFSET, 16'h0000);
        upstream_rx_target_abort = 1'b1;
        partner.send('{1'b0, 1'b1, 1'b0, TRAFFIC_OB_POSTED, 1'b0});
        cfg_rd("sent abort", SEC_STATUS_OFFSET, 16'h0800);
        {rx_system_error, rx_unsupported_compl} = 2'b11;
        @(negedge clock);
        {rx_system_error, rx_unsupported_compl} = 2'b00;
        cfg_rd("sys and ur", SEC_STATUS_OFFSET, 16'h6800);
        for (int i = 0; i < 5; i++)
        begin
            cfg_wr(SEC_STATUS_OFFSET, 16'hffff);
            upstream_parity_clear = 1'b1;
            @(negedge clock);
            upstream_parity_clear = 1'b0;
            parity_response_enable = (i != 0);
            cls = traffic_type'((i == 0) ? 3 : i - 1);
            partner.send('{1'b0, 1'b0, 1'b1, cls, 1'b0});
            cfg_rd("status parity", SEC_STATUS_OFFSET,
                {cls[1], 6'h00, cls == TRAFFIC_IB_COMPL && i != 0, 8'h00});
            check("up det", {15'h0000, up_det}, {15'h0000, !cls[1]});
            check("up master", {15'h0000, up_mas}, {15'h0000, cls == TRAFFIC_OB_COMPL});
        end
        cfg_wr(SEC_STATUS_OFFSET, 16'hffff);
        partner.send('{1'b0, 1'b0, 1'b0, TRAFFIC_OB_POSTED, 1'b1});
        cfg_rd("poisoned write", SEC_STATUS_OFFSET, 16'h0100);
        cfg_wr(SEC_STATUS_OFFSET, 16'hffff);
        parity_response_enable = 1'b0;
        partner.send('{1'b0, 1'b0, 1'b0, TRAFFIC_OB_POSTED, 1'b1});
        cfg_rd("poisoned write gated", SEC_STATUS_OFFSET, 16'h0000);
        cfg_wr(MEM_BASE_OFFSET, 16'h1230);
        mem_limit_value = 16'h4560;
        probe(32'h122fffff, 1'b0);
        probe(32'h12300000, 1'b1);
        probe(32'h456fffff, 1'b1);
        probe(32'h45700000, 1'b0);
        final_report;
    end
    initial
    begin
        #5000;
        err_count++;
        final_report;
    end
endmodule
bind bridge_secondary_status_and_mem_base bridge_status_sva chk (.clock(clock),
    .resetn(resetn), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .port_event(port_event),
    .mem_limit_value(mem_limit_value), .mem_req_valid(mem_req_valid),
    .mem_req_addr(mem_req_addr), .mem_to_port(mem_to_port),
    .upstream_detected_parity_flag(upstream_detected_parity_flag),
    .upstream_master_parity_flag(upstream_master_parity_flag),
    .mem_window_base_field(mem_window_base_field));

// File: test/bridge_status_sva.sv
`timescale 1ns/1ps
module bridge_status_sva
    import bridge_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire cfg_req_type cfg_req,
    input wire logic [15:0] cfg_rdata,
    input wire port_event_type port_event,
    input wire logic [15:0] mem_limit_value,
    input wire logic mem_req_valid,
    input wire logic [31:0] mem_req_addr,
    input wire logic mem_to_port,
    input wire logic upstream_detected_parity_flag,
    input wire logic upstream_master_parity_flag,
    input wire logic [15:0] mem_window_base_field
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    logic in_win;
    logic base_wr;
    logic ob_compl;
    assign in_win = mem_window_base_field[15:4] <= mem_req_addr[31:20]
        && mem_req_addr[31:20] <= mem_limit_value[15:4];
    assign base_wr = cfg_req.wr && cfg_req.offset == MEM_BASE_OFFSET;
    assign ob_compl = port_event.poison_seen && port_event.poison_class == TRAFFIC_OB_COMPL;
    a_win_inside: assert property (mem_req_valid && in_win |=> mem_to_port)
        else $error("window hit not forwarded");
    a_win_outside: assert property (!(mem_req_valid && in_win) |=> !mem_to_port)
        else $error("forward outside window");
    a_base_write: assert property (base_wr && cfg_req.byte_en == 2'h3 |=>
        mem_window_base_field == {$past(cfg_req.wdata[15:4]), 4'h0})
        else $error("base write lost");
    a_base_hold: assert property (!base_wr |=> $stable(mem_window_base_field))
        else $error("base changed without write");
    a_base_low: assert property (mem_window_base_field[3:0] == 4'h0)
        else $error("base low bits set");
    a_status_fixed: assert property (cfg_req.rd && cfg_req.offset == SEC_STATUS_OFFSET |=>
        cfg_rdata[10:9] == 2'h0 && cfg_rdata[7:0] == 8'h00)
        else $error("status fixed bits set");
    a_up_det_set: assert property (port_event.poison_seen
        && !port_event.poison_class[1] |=> upstream_detected_parity_flag)
        else $error("upstream detected flag missed");
    a_up_master_only: assert property (!upstream_master_parity_flag && !ob_compl
        |=> !upstream_master_parity_flag)
        else $error("upstream master flag spurious");
    cover property (mem_req_valid && in_win);
    cover property (base_wr);
    cover property (ob_compl);
endmodule

// File: test/link_partner_model.sv
`timescale 1ns/1ps
module link_partner_model
    import bridge_cfg_pkg::*;
(
    input wire logic clock,
    output port_event_type port_event
);
    initial port_event = '0;
    // Each link event is a single-cycle pulse launched on a falling edge.
    task automatic send(input port_event_type ev);
        @(negedge clock);
        port_event = ev;
        @(negedge clock);
        port_event = '0;
    endtask
endmodule

// File: verilog/bridge_secondary_status_and_mem_base.sv
// Overview of operation
// R1: Set received completer-abort flag, bit 12, on a Completer Abort completion.
// R2: Set sent completer-abort flag, bit 11, only when upstream target abort is set.
// R3: Select timing, back-to-back and high-speed capable bits read zero, not writable.
// R4: Set master parity bit 8 when enabled and poisoned completion or write.
// R5: With parity response disabled, master parity bit 8 never sets.
// R6: Reserved status bits 6, 4:0 and base bits 3:0 read zero.
// R7: Parity flags log per the outbound and inbound traffic matrix.
// R8: Upstream detected parity normally covers upstream master parity cases.
// R9: Forward memory accesses inside the non-prefetchable window to the port.
// R10: Base bits 15:4 are read/write and hold address bits 31:20.
// R11: Base low address bits decode as zero, limit low bits as all ones.
// R12: Inside when base field <= address 31:20 <= limit field.
// R13: Software clears error bits by writing one; writing zero keeps them.
`timescale 1ns/1ps

module bridge_secondary_status_and_mem_base
    import bridge_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire cfg_req_type cfg_req,
    output logic [15:0] cfg_rdata,
    output logic cfg_hit,
    input wire port_event_type port_event,
    input wire logic parity_response_enable,
    input wire logic upstream_rx_target_abort,
    input wire logic rx_system_error,
    input wire logic rx_unsupported_compl,
    input wire logic [15:0] mem_limit_value,
    input wire logic mem_req_valid,
    input wire logic [31:0] mem_req_addr,
    output logic mem_to_port,
    output logic upstream_detected_parity_flag,
    output logic upstream_master_parity_flag,
    input wire logic upstream_parity_clear,
    output logic [15:0] mem_window_base_field
);

    // ========================================================================
    // Helpers.
    // ========================================================================
    function automatic logic [15:0] byte_mask(input logic [1:0] be);
        byte_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [WIN_FIELD_W-1:0] win_field(input logic [15:0] v);
        win_field = v[WIN_FIELD_LSB +: WIN_FIELD_W];
    endfunction

    // Poisoned traffic that came in from the link.
    function automatic logic is_inbound(input traffic_type cls);
        is_inbound = cls == TRAFFIC_IB_POSTED || cls == TRAFFIC_IB_COMPL;
    endfunction

    // Poisoned traffic that the port sent out on the link.
    function automatic logic is_outbound(input traffic_type cls);
        is_outbound = cls == TRAFFIC_OB_POSTED || cls == TRAFFIC_OB_COMPL;
    endfunction

    // A new event wins over a write-one clear in the same cycle.
    function automatic logic [15:0] sticky_update(
        input logic [15:0] cur,
        input logic [15:0] clr,
        input logic [15:0] ev
    );
        sticky_update = (cur & ~clr) | ev;
    endfunction

    // Inclusive range test on the upper address field.
    function automatic logic in_window(
        input logic [WIN_FIELD_W-1:0] lo,
        input logic [WIN_FIELD_W-1:0] hi,
        input logic [WIN_FIELD_W-1:0] a
    );
        in_window = lo <= a && a <= hi;
    endfunction

    // ========================================================================
    // Event decode.
    // ========================================================================
    logic ev_det_parity;
    logic ev_master_parity;
    logic ev_up_det;
    logic ev_up_master;
    logic ev_rx_abort;
    logic ev_sent_abort;
    logic poison_in;
    logic poison_out;
    logic poison_in_compl;
    logic poison_out_compl;

    always_comb
    begin
        poison_in = port_event.poison_seen && is_inbound(port_event.poison_class);
        poison_out = port_event.poison_seen && is_outbound(port_event.poison_class);
        poison_in_compl = port_event.poison_seen &&
            port_event.poison_class == TRAFFIC_IB_COMPL;
        poison_out_compl = port_event.poison_seen &&
            port_event.poison_class == TRAFFIC_OB_COMPL;
        // R7: inbound detected parity
        ev_det_parity = poison_in;
        // R4: poison sets master
        // R5: enable gates
        ev_master_parity = parity_response_enable &&
            (poison_in_compl || port_event.poisoned_write_sent);
        // R7: outbound detected parity
        ev_up_det = poison_out;
        // An outbound completion sets both upstream flags, so detected covers master.
        // R8: detected covers master
        ev_up_master = poison_out_compl;
        // R1: abort received
        ev_rx_abort = port_event.rx_completer_abort;
        // R2: passed-down abort
        ev_sent_abort = port_event.completed_with_abort && upstream_rx_target_abort;
    end

    // ========================================================================
    // Configuration write decode.
    // ========================================================================
    logic status_wr;
    logic base_wr;
    logic [15:0] wmask;

    always_comb
    begin
        wmask = byte_mask(cfg_req.byte_en);
        status_wr = cfg_req.wr && cfg_req.offset == SEC_STATUS_OFFSET;
        base_wr = cfg_req.wr && cfg_req.offset == MEM_BASE_OFFSET;
    end

    // ========================================================================
    // Downstream side error status.
    // ========================================================================
    logic [15:0] downstream_side_error_status_r;
    logic [15:0] downstream_side_error_status_nxt;
    logic [15:0] clr_bits;
    logic [15:0] set_bits;

    always_comb
    begin
        set_bits = '0;
        set_bits[DET_PARITY_BIT] = ev_det_parity;
        set_bits[RX_SYS_ERR_BIT] = rx_system_error;
        set_bits[RX_MASTER_ABORT_BIT] = rx_unsupported_compl;
        set_bits[RX_ABORT_BIT] = ev_rx_abort;
        set_bits[SENT_ABORT_BIT] = ev_sent_abort;
        set_bits[MASTER_PARITY_BIT] = ev_master_parity;
        // R13: one clears
        clr_bits = '0;
        if (status_wr)
        begin
            clr_bits = cfg_req.wdata & wmask & STATUS_W1C_MASK;
        end
        // R3: hardwired bits zero
        // R6: reserved bits zero
        downstream_side_error_status_nxt = STATUS_W1C_MASK &
            sticky_update(downstream_side_error_status_r, clr_bits, set_bits);
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            downstream_side_error_status_r <= STATUS_RESET;
        end
        else
        begin
            downstream_side_error_status_r <= downstream_side_error_status_nxt;
        end
    end

    // ========================================================================
    // Downstream memory window base.
    // ========================================================================
    logic [WIN_FIELD_W-1:0] downstream_mem_window_base_r;
    logic [WIN_FIELD_W-1:0] downstream_mem_window_base_nxt;
    logic [15:0] base_merged;

    always_comb
    begin
        // Merging per byte lane lets a one-byte write keep the other lane.
        base_merged = (mem_window_base_field & ~wmask) | (cfg_req.wdata & wmask);
        // R10: base writable
        downstream_mem_window_base_nxt = downstream_mem_window_base_r;
        if (base_wr)
        begin
            downstream_mem_window_base_nxt = win_field(base_merged);
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            downstream_mem_window_base_r <= MEM_BASE_RESET[WIN_FIELD_LSB +: WIN_FIELD_W];
        end
        else
        begin
            downstream_mem_window_base_r <= downstream_mem_window_base_nxt;
        end
    end

    // R6: base low bits zero
    assign mem_window_base_field = {downstream_mem_window_base_r, {WIN_FIELD_LSB{1'b0}}};

    // ========================================================================
    // Upstream parity flags.
    // ========================================================================
    // These flags belong to the upstream status register, which clears them by pulse.
    // The matrix is decoded here so that both sides share one classification.
    logic up_det_r;
    logic up_det_nxt;
    logic up_master_r;
    logic up_master_nxt;

    always_comb
    begin
        // R7: upstream logging
        up_det_nxt = (up_det_r && !upstream_parity_clear) || ev_up_det;
        up_master_nxt = (up_master_r && !upstream_parity_clear) || ev_up_master;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            up_det_r <= 1'b0;
            up_master_r <= 1'b0;
        end
        else
        begin
            up_det_r <= up_det_nxt;
            up_master_r <= up_master_nxt;
        end
    end

    assign upstream_detected_parity_flag = up_det_r;
    assign upstream_master_parity_flag = up_master_r;

    // ========================================================================
    // Read path.
    // ========================================================================
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    always_comb
    begin
        cfg_hit = cfg_req.offset == SEC_STATUS_OFFSET || cfg_req.offset == MEM_BASE_OFFSET;
        rdata_nxt = rdata_r;
        if (cfg_req.rd)
        begin
            // Offsets outside this block read as zero.
            case (cfg_req.offset)
                SEC_STATUS_OFFSET:
                begin
                    rdata_nxt = downstream_side_error_status_r;
                end
                MEM_BASE_OFFSET:
                begin
                    rdata_nxt = mem_window_base_field;
                end
                default:
                begin
                    rdata_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            rdata_r <= '0;
        else
            rdata_r <= rdata_nxt;
    end

    assign cfg_rdata = rdata_r;

    // ========================================================================
    // Window decode.
    // ========================================================================
    logic [WIN_FIELD_W-1:0] addr_hi;
    logic [WIN_FIELD_W-1:0] limit_hi;
    logic to_port_r;
    logic to_port_nxt;

    always_comb
    begin
        addr_hi = mem_req_addr[ADDR_LOW_W +: WIN_FIELD_W];
        limit_hi = win_field(mem_limit_value);
        // Comparing bits 31:20 alone equals a base padded with zeros
        // and a limit padded with ones below bit 20.
        // R9: forward window hits
        // R11: implied low bits
        // R12: inclusive range
        to_port_nxt = mem_req_valid &&
            in_window(downstream_mem_window_base_r, limit_hi, addr_hi);
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            to_port_r <= 1'b0;
        else
            to_port_r <= to_port_nxt;
    end

    assign mem_to_port = to_port_r;

endmodule
